// [rtl/sbpr_pkg.sv]
// Shared constants for the sixteen-bit serial/parallel shift register
`default_nettype none
package sbpr_pkg;
    // ******************************************
    // Widths and depths
    // ******************************************
    localparam int STAGE_W    = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int CNT_W      = 4;
    localparam int SYNC_W     = 20;
    // ******************************************
    // Field positions in the synchronised pin vector
    // ******************************************
    localparam int PIN_CS     = 19;
    localparam int PIN_MODE   = 18;
    localparam int PIN_CP     = 17;
    localparam int PIN_SI     = 16;
    // ******************************************
    // Counts and values after reset
    // ******************************************
    localparam logic [CNT_W-1:0]   LAST_BIT    = 4'hF;
    localparam logic [CNT_W-1:0]   CNT_RST     = 4'h0;
    localparam logic [STAGE_W-1:0] STAGE_RST   = 16'h0000;
    // Clock pin taken as low out of reset: a pin parked low gives no false fall
    localparam logic [SYNC_W-1:0]  SYNC_RST    = 20'hC0000;
    localparam logic               CP_LVL_RST  = 1'b0;
endpackage
`default_nettype wire

// [rtl/sbpr_fifo.sv]
// Word FIFO with registered output stage and back-pressure
`default_nettype none
module sbpr_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Filling side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    // Draining side
    output var  logic         out_valid,
    output var  logic [W-1:0] out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    logic          push;
    logic          pop;

    assign push = in_valid && in_ready;
    assign pop  = (cnt_q != '0) && (!out_valid || out_ready);

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // ******************************************
    // Storage
    // ******************************************
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q     <= '0;
            rd_q     <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d < (AW + 1)'(DEPTH));
        end
    end

    // ******************************************
    // Output stage
    // ******************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_q];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [rtl/sbpr_shift_reg.sv]
// Sixteen-bit serial/parallel-in, serial-out shift register core
`default_nettype none
// Contract
// [RULE_01] With chip select high, clock edges are ignored and all sixteen stages hold.
// [RULE_02] Chip select low, mode low: each clock fall shifts serial input into stage 0 onward.
// [RULE_03] Chip select low, mode high: each clock fall loads all sixteen parallel inputs.
// [RULE_04] The serial output always shows stage 15, so data leaves most significant first.
// [RULE_05] The controller keeps the clock low whenever it raises chip select; the model starts with cp high and pulses cp while deselected in the hold test.
// [RULE_06] With no reset pin, contents are undefined until a load or sixteen shifts.
module sbpr_shift_reg
    import sbpr_pkg::*;
#(
    parameter int WORD_W = STAGE_W,
    parameter int DEPTH  = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    // Device pins
    input  wire logic              cs_n,
    input  wire logic              mode,
    input  wire logic              cp,
    input  wire logic              serial_in,
    input  wire logic [WORD_W-1:0] parallel_in,
    output var  logic              serial_out,
    // Status
    output var  logic              stage_valid_q,
    output var  logic              overflow_q,
    output var  logic              capture_ready,
    // Captured word stream
    output var  logic              word_valid,
    output var  logic [WORD_W-1:0] word_data,
    input  wire logic              word_ready
);
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] sync3_q;
    logic              cp_lvl_q;
    logic              cp_agree;
    logic              fall_ev;
    logic              shift_ev;
    logic              load_ev;
    logic              word_done;
    logic [WORD_W-1:0] stage_q;
    logic [WORD_W-1:0] stage_d;
    logic [CNT_W-1:0]  bit_cnt_q;
    logic              cap_valid_q;
    logic [WORD_W-1:0] cap_data_q;

    // ******************************************
    // Pin synchronisers
    // ******************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
            sync3_q <= SYNC_RST;
        end else begin
            sync1_q <= {cs_n, mode, cp, serial_in, parallel_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign cp_agree = (sync2_q[PIN_CP] == sync3_q[PIN_CP]);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cp_lvl_q <= CP_LVL_RST;
        end else if (cp_agree) begin
            cp_lvl_q <= sync3_q[PIN_CP];
        end
    end

    // ******************************************
    // Clock fall decode
    // ******************************************
    assign fall_ev   = cp_lvl_q && cp_agree && !sync3_q[PIN_CP];
    assign shift_ev  = fall_ev && !sync3_q[PIN_CS] && !sync3_q[PIN_MODE]; // RULE_01
    assign load_ev   = fall_ev && !sync3_q[PIN_CS] && sync3_q[PIN_MODE];  // RULE_01
    assign word_done = shift_ev && (bit_cnt_q == LAST_BIT);

    always_comb begin
        stage_d = stage_q;
        if (load_ev) begin
            stage_d = sync3_q[WORD_W-1:0]; // RULE_03
        end else if (shift_ev) begin
            stage_d = {stage_q[WORD_W-2:0], sync3_q[PIN_SI]}; // RULE_02
        end
    end

    // ******************************************
    // Register stages
    // ******************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_q <= STAGE_RST;
        end else begin
            stage_q <= stage_d;
        end
    end

    assign serial_out = stage_q[WORD_W-1]; // RULE_04

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_q     <= CNT_RST;
            stage_valid_q <= 1'b0;
        end else begin
            if (load_ev) begin
                bit_cnt_q <= CNT_RST;
            end else if (shift_ev) begin
                bit_cnt_q <= bit_cnt_q + 1'b1;
            end
            if (load_ev || word_done) begin
                stage_valid_q <= 1'b1; // RULE_06
            end
        end
    end

    // ******************************************
    // Word capture into FIFO
    // ******************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_valid_q <= 1'b0;
            cap_data_q  <= STAGE_RST;
            overflow_q  <= 1'b0;
        end else begin
            cap_valid_q <= word_done;
            if (word_done) begin
                cap_data_q <= stage_d;
            end
            if (cap_valid_q && !capture_ready) begin
                overflow_q <= 1'b1;
            end
        end
    end

    sbpr_fifo #(
        .W     (WORD_W),
        .DEPTH (DEPTH)
    ) i_sbpr_fifo (
        .clk       (ref_clk),
        .arst_n    (arst_n),
        .in_valid  (cap_valid_q),
        .in_data   (cap_data_q),
        .in_ready  (capture_ready),
        .out_valid (word_valid),
        .out_data  (word_data),
        .out_ready (word_ready)
    );

    // ******************************************
    // Assertions
    // ******************************************
    a_hold_freeze: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_01
        (sync3_q[PIN_CS] || !fall_ev) |=> $stable(stage_q))
        else $error("Stages changed without a selected clock fall");

    a_shift_move: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_02
        shift_ev |=> stage_q == {$past(stage_q[WORD_W-2:0]), $past(sync3_q[PIN_SI])})
        else $error("Shift did not move stages toward stage 15");

    a_load_word: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_03
        load_ev |=> stage_q == $past(sync3_q[WORD_W-1:0]))
        else $error("Parallel load did not copy all inputs");

    a_out_msb: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_04
        load_ev |=> serial_out == $past(sync3_q[WORD_W-1]))
        else $error("Serial output does not show top stage after load");

    a_valid_track: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_06
        (load_ev || word_done) |=> stage_valid_q ##1 stage_valid_q)
        else $error("Contents not marked defined after load or full shift");

    a_fall_single: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_02
        fall_ev |=> !fall_ev)
        else $error("One clock fall was decoded twice");

    a_hold_cs: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_01
        sync3_q[PIN_CS] |=> $stable(stage_q) && $stable(bit_cnt_q))
        else $error("Stages or bit count moved while deselected");

    a_shift_count: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_02
        shift_ev |=> bit_cnt_q == $past(bit_cnt_q) + 1'b1)
        else $error("Shift did not advance the bit count");

    a_load_count: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_03
        load_ev |=> bit_cnt_q == CNT_RST)
        else $error("Parallel load did not restart the bit count");

    a_serial_top: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_04
        serial_out == stage_q[WORD_W-1])
        else $error("Serial output differs from stage 15");

    a_valid_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_06
        stage_valid_q |=> stage_valid_q)
        else $error("Defined-contents flag dropped without reset");

    // ******************************************
    // Word stream checks
    // ******************************************
    a_word_capture: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_02
        word_done |=> cap_valid_q && (cap_data_q == stage_q))
        else $error("Captured word differs from stages after sixteenth shift");

    a_word_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (word_valid && !word_ready) |=> word_valid && $stable(word_data))
        else $error("Word changed or vanished before it was taken");

    a_drop_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (cap_valid_q && !capture_ready) |=> overflow_q)
        else $error("Dropped word did not raise the overflow flag");

    a_overflow_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n)
        overflow_q |=> overflow_q)
        else $error("Overflow flag cleared without reset");

    c_shift: cover property (@(posedge ref_clk) disable iff (!arst_n) shift_ev);
    c_load: cover property (@(posedge ref_clk) disable iff (!arst_n) load_ev);
    c_hold: cover property (@(posedge ref_clk) disable iff (!arst_n)
        fall_ev && sync3_q[PIN_CS]);
    c_word: cover property (@(posedge ref_clk) disable iff (!arst_n) word_valid && word_ready);
    c_overflow: cover property (@(posedge ref_clk) disable iff (!arst_n) $rose(overflow_q));
endmodule
`default_nettype wire

// [verification/sbpr_ctrl_model.sv]
// Controller model that drives the device pins
`default_nettype none
module sbpr_ctrl_model
    import sbpr_pkg::*;
(
    // Clock
    input  wire logic               ref_clk,
    // Device pins
    output var  logic               cs_n,
    output var  logic               mode,
    output var  logic               cp,
    output var  logic               serial_in,
    output var  logic [STAGE_W-1:0] parallel_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n        = 1'b1;
        mode        = 1'b0;
        cp          = 1'b1;
        serial_in   = 1'b0;
        parallel_in = 16'h0000;
    end
    // Pins change while cp is low (still high from the initial values on the first call), then one full cp pulse
    task automatic pulse(input logic sel_n, input logic m, input logic si,
                         input logic [STAGE_W-1:0] p);
        @(posedge ref_clk);
        cs_n        <= sel_n;
        mode        <= m;
        serial_in   <= si;
        parallel_in <= p;
        @(posedge ref_clk);
        cp <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cp <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// [verification/test_sbpr_shift_reg.sv]
// Self-checking bench for the shift register
`default_nettype none
module test_sbpr_shift_reg
    import sbpr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [STAGE_W-1:0] word;
        logic               so;
    } sbpr_row_t;
    logic               ref_clk;
    logic               arst_n;
    logic               cs_n;
    logic               mode;
    logic               cp;
    logic               serial_in;
    logic [STAGE_W-1:0] parallel_in;
    logic               serial_out;
    logic               stage_valid_q;
    logic               overflow_q;
    logic               capture_ready;
    logic               word_valid;
    logic [STAGE_W-1:0] word_data;
    logic               word_ready;
    logic [STAGE_W-1:0] exp_q;
    int                 failures = 0;
    int                 n_compared = 0;
    int                 k;
    sbpr_row_t          rows [4] = '{'{16'h8001, 1'b1}, '{16'h7FFF, 1'b0},
                                     '{16'hFFFF, 1'b1}, '{16'h0000, 1'b0}};
    sbpr_shift_reg #(.WORD_W(STAGE_W), .DEPTH(FIFO_DEPTH)) i_sbpr_shift_reg (
        .ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .mode(mode), .cp(cp),
        .serial_in(serial_in), .parallel_in(parallel_in), .serial_out(serial_out),
        .stage_valid_q(stage_valid_q), .overflow_q(overflow_q),
        .capture_ready(capture_ready), .word_valid(word_valid),
        .word_data(word_data), .word_ready(word_ready));
    sbpr_ctrl_model i_sbpr_ctrl_model (
        .ref_clk(ref_clk), .cs_n(cs_n), .mode(mode), .cp(cp),
        .serial_in(serial_in), .parallel_in(parallel_in));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [STAGE_W-1:0] got, input logic [STAGE_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Sixteen shifts, most significant bit first, tracking the expected stages
    task automatic shift_word(input logic [STAGE_W-1:0] w);
        for (int j = 15; j >= 0; j--) begin
            i_sbpr_ctrl_model.pulse(1'b0, 1'b0, w[j], ~exp_q);
            exp_q = {exp_q[14:0], w[j]};
            check(16'(serial_out), 16'(exp_q[15]));
        end
    endtask
    // Bounded wait for a captured word, then accept it
    task automatic take_word(input logic [STAGE_W-1:0] w);
        k = 0;
        while (word_valid !== 1'b1 && k < 20) begin
            @(posedge ref_clk);
            k++;
        end
        if (word_valid !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, word_valid, 1'b1);
        end else begin
            check(word_data, w);
        end
        word_ready <= 1'b1;
        @(posedge ref_clk);
        word_ready <= 1'b0;
    endtask
    initial begin
        arst_n     = 1'b0;
        word_ready = 1'b0;
        exp_q      = 16'h0000;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        check({11'h000, serial_out, stage_valid_q, overflow_q, capture_ready, word_valid},
              16'h0002);
        $display("test reset done");
        foreach (rows[i]) begin
            i_sbpr_ctrl_model.pulse(1'b0, 1'b1, ~rows[i].so, rows[i].word);
            exp_q = rows[i].word;
            check(16'(serial_out), 16'(rows[i].so));
            check(16'(stage_valid_q), 16'h0001);
        end
        $display("test parallel load done");
        shift_word(16'hA35A);
        take_word(16'hA35A);
        $display("test serial shift done");
        i_sbpr_ctrl_model.pulse(1'b1, 1'b1, 1'b0, ~exp_q);
        check(16'(serial_out), 16'(exp_q[15]));
        i_sbpr_ctrl_model.pulse(1'b1, 1'b0, ~exp_q[14], ~exp_q);
        check(16'(serial_out), 16'(exp_q[15]));
        $display("test hold done");
        for (int w = 0; w < 34; w++) begin
            shift_word(16'h1000 + 16'(w));
        end
        repeat (4) @(posedge ref_clk);
        check({14'h0000, capture_ready, overflow_q}, 16'h0001);
        word_ready <= 1'b1;
        k = 0;
        for (int c = 0; c < 100; c++) begin
            @(posedge ref_clk);
            if (word_valid === 1'b1) begin
                check(word_data, 16'h1000 + 16'(k));
                k++;
            end
        end
        check(16'(k), 16'(FIFO_DEPTH + 1));
        $display("test fifo fill and drain done");
        // Mid-run reset with the clock pin parked low and the chip still selected
        word_ready <= 1'b0;
        arst_n     <= 1'b0;
        @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        check({11'h000, serial_out, stage_valid_q, overflow_q, capture_ready, word_valid},
              16'h0002);
        exp_q = 16'h0000;
        shift_word(16'h5AC3);
        take_word(16'h5AC3);
        check(16'(stage_valid_q), 16'h0001);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
